// ==== verilog/digital_input_conditioner.sv ====
// Purpose: Per-channel digital input conditioning with periodic input byte
// Assumes: Line and fault inputs arrive asynchronously from the field front end
// Notes: Registers are reached over AXI4-Lite; no output data bytes exist
`timescale 1ns/1ps
`default_nettype none

module digital_input_conditioner
  import dic_pkg::*;
#(
  parameter int unsigned NUM_CH = MAX_CH,
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned SEND_LEN = SEND_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [NUM_CH-1:0] LINE_I,
  input wire logic [NUM_CH-1:0] FAULT_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic [7:0] DATA_BYTE_O,
  output logic DATA_VALID_O
);

  // Refuse variants the byte layout cannot hold
  if (NUM_CH < 2 || NUM_CH > MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be 2 or 3");
  end
  // Counters are CNT_W bits wide
  if (TICK_LEN < 1 || TICK_LEN >= (1 << CNT_W) || SEND_LEN < 1 || SEND_LEN >= (1 << CNT_W)) begin : g_bad_len
    $error("TICK_LEN and SEND_LEN out of counter range");
  end

  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_LEN - 1);
  localparam logic [CNT_W-1:0] SEND_LAST = CNT_W'(SEND_LEN - 1);

  state_s st;  // Registered state
  state_s next_st;  // Next state

  // Delay code to tick count; code 0 means no delay
  function automatic logic [9:0] dly_limit(input logic [1:0] code);
    case (code)
      2'h1: dly_limit = DLY_CODE1_MS;
      2'h2: dly_limit = DLY_CODE2_MS;
      2'h3: dly_limit = DLY_CODE3_MS;
      default: dly_limit = 10'h000;
    endcase
  endfunction

  // Register index of an address, all ones when unmapped
  function automatic logic [1:0] cfg_index(input logic [7:0] addr);
    case (addr)
      REG_CFG0: cfg_index = 2'h0;
      REG_CFG1: cfg_index = 2'h1;
      REG_CFG2: cfg_index = (NUM_CH > 2) ? 2'h2 : 2'h3;
      default: cfg_index = 2'h3;
    endcase
  endfunction

  // Packed input byte: state then fault flag per channel
  function automatic logic [7:0] pack_byte(input logic [MAX_CH-1:0] lvl, input logic [MAX_CH-1:0] flt,
                                           input logic [MAX_CH-1:0][7:0] cfg);
    logic [7:0] b;
    b = 8'h00;
    for (int n = 0; n < NUM_CH; n++) begin
      b[2*n] = lvl[n];
      b[2*n+1] = flt[n] & cfg[n][CFG_FAULT_EN_BIT];
    end
    return b;
  endfunction

  // Next state logic
  always_comb begin
    cfg_s c;
    logic [1:0] idx;
    logic want;
    logic [9:0] lim;
    c = '0;
    idx = 2'h0;
    want = 1'b0;
    lim = 10'h000;
    next_st = st;
    next_st.data_valid = 1'b0;
    next_st.tick = 1'b0;

    // Input synchronisers: level taken once stages two and three agree
    next_st.line_s1 = '0;
    next_st.flt_s1 = '0;
    next_st.line_s1[NUM_CH-1:0] = LINE_I;
    next_st.flt_s1[NUM_CH-1:0] = FAULT_I;
    next_st.line_s2 = st.line_s1;
    next_st.line_s3 = st.line_s2;
    next_st.flt_s2 = st.flt_s1;
    next_st.flt_s3 = st.flt_s2;
    for (int n = 0; n < NUM_CH; n++) begin
      if (st.line_s2[n] == st.line_s3[n]) begin
        next_st.line_f[n] = st.line_s3[n];
      end
      if (st.flt_s2[n] == st.flt_s3[n]) begin
        next_st.flt_f[n] = st.flt_s3[n];
      end
    end

    // Millisecond tick for the delay filters
    if (st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
    end

    for (int n = 0; n < NUM_CH; n++) begin
      c = cfg_s'(st.cfg[n]);
      want = st.line_f[n] ^ c.invert;
      lim = want ? dly_limit(c.on_dly) : dly_limit(c.off_dly);
      if (want == st.level[n]) begin
        next_st.dcnt[n] = 10'h000;
      end else if (lim == 10'h000) begin
        next_st.level[n] = want;
        next_st.dcnt[n] = 10'h000;
      end else if (st.tick) begin
        if (st.dcnt[n] == lim) begin
          next_st.level[n] = want;
          next_st.dcnt[n] = 10'h000;
        end else begin
          next_st.dcnt[n] = st.dcnt[n] + 10'h001;
        end
      end
    end

    if (st.send_cnt == SEND_LAST) begin
      next_st.send_cnt = '0;
      next_st.data_byte = pack_byte(st.level, st.flt_f, st.cfg);
      next_st.data_valid = 1'b1;
    end else begin
      next_st.send_cnt = st.send_cnt + 1'b1;
    end

    // Write address and data taken in either order
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      next_st.w_have = 1'b1;
      next_st.wdata = S_AXI_WDATA_I[7:0];
      next_st.wstrb0 = S_AXI_WSTRB_I[0];
    end
    // Both halves present: perform write and answer
    if (st.aw_have && st.w_have && !st.bvalid) begin
      idx = cfg_index(st.awaddr);
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (idx != 2'h3) begin
        // config byte store; unused bits kept zero
        if (st.wstrb0) begin
          next_st.cfg[idx] = st.wdata & CFG_USED_MASK;
        end
      end else if (st.awaddr != REG_SENT && st.awaddr != REG_LIVE) begin
        next_st.bresp = RESP_SLVERR;
      end
    end else if (st.bvalid && S_AXI_BREADY_I) begin
      next_st.bvalid = 1'b0;
    end

    // Read: one cycle to answer, held until taken
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      idx = cfg_index(S_AXI_ARADDR_I);
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (idx != 2'h3) begin
        next_st.rdata[7:0] = st.cfg[idx];
      end else if (S_AXI_ARADDR_I == REG_SENT) begin
        next_st.rdata[7:0] = st.data_byte;
      end else if (S_AXI_ARADDR_I == REG_LIVE) begin
        next_st.rdata[7:0] = pack_byte(st.level, st.flt_f, st.cfg);
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && S_AXI_RREADY_I) begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st <= '0;
    end else if (CE_I) begin
      st <= next_st;
    end
  end

  // Handshake outputs; ready drops while clock enable is low so nothing is lost
  assign S_AXI_AWREADY_O = CE_I && !st.aw_have && !st.bvalid;
  assign S_AXI_WREADY_O = CE_I && !st.w_have && !st.bvalid;
  assign S_AXI_ARREADY_O = CE_I && !st.rvalid;
  assign S_AXI_BVALID_O = st.bvalid;
  assign S_AXI_BRESP_O = st.bresp;
  assign S_AXI_RVALID_O = st.rvalid;
  assign S_AXI_RDATA_O = st.rdata;
  assign S_AXI_RRESP_O = st.rresp;
  // only an input byte leaves the block
  assign DATA_BYTE_O = st.data_byte;
  assign DATA_VALID_O = st.data_valid;

  // Assertion helpers
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  logic [CNT_W:0] gap_cnt;  // Enabled cycles since last byte
  logic seen_one;  // A first byte has gone out
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      gap_cnt <= '0;
      seen_one <= 1'b0;
    end else if (CE_I) begin
      gap_cnt <= st.data_valid ? (CNT_W+1)'(1) : gap_cnt + 1'b1;
      seen_one <= seen_one | st.data_valid;
    end
  end

  a_send_period_gap: assert property (st.data_valid && seen_one && CE_I |-> gap_cnt == (CNT_W+1)'(SEND_LEN))
    else $error("input byte period wrong");

  a_empty_high_bits: assert property ((DATA_BYTE_O >> (2*NUM_CH)) == 8'h00)
    else $error("bits above last channel not empty");

  a_state_bit_pack: assert property ($rose(DATA_VALID_O) |-> DATA_BYTE_O[0] == $past(st.level[0]))
    else $error("channel state bit wrong");

  a_fault_gate_on: assert property ($rose(DATA_VALID_O) |->
      DATA_BYTE_O[1] == ($past(st.flt_f[0]) && $past(st.cfg[0][CFG_FAULT_EN_BIT])))
    else $error("fault flag not gated by enable");

  a_follow_no_delay: assert property (CE_I && st.cfg[1][5:2] == 4'h0 &&
      (st.line_f[1] ^ st.cfg[1][CFG_INVERT_BIT]) != st.level[1] |=> st.level[1] == $past(st.line_f[1] ^ st.cfg[1][CFG_INVERT_BIT]))
    else $error("undelayed channel did not follow");

  a_on_delay_wait: assert property ($rose(st.level[0]) && $past(st.cfg[0][3:2]) != 2'h0 |->
      $past(st.tick) && $past(st.dcnt[0]) == dly_limit($past(st.cfg[0][3:2])))
    else $error("rising edge passed early");

  a_off_delay_wait: assert property ($fell(st.level[0]) && $past(st.cfg[0][5:4]) != 2'h0 |->
      $past(st.tick) && $past(st.dcnt[0]) == dly_limit($past(st.cfg[0][5:4])))
    else $error("falling edge passed early");

  a_cfg_after_reset: assert property ($fell(RST_I) |-> st.cfg == '0)
    else $error("config not cleared by reset");

endmodule
`default_nettype wire

// ==== verilog/dic_pkg.sv ====
// Purpose: Shared constants and types for the digital input conditioner
// Assumes: 200 MHz system clock, AXI4-Lite register access
// Notes: Channel arrays are sized for the largest variant
package dic_pkg;
  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned TICK_US = 1000;  // Delay time base, 1 ms
  localparam int unsigned TICK_CYCLES = TICK_US * CYC_PER_US;
  localparam int unsigned SEND_PERIOD_US = 6500;  // Input byte period, 6.5 ms
  localparam int unsigned SEND_CYCLES = SEND_PERIOD_US * CYC_PER_US;
  localparam int unsigned CNT_W = 21;  // Width of cycle counters
  // Delay selections in ms, counted in ticks
  localparam logic [9:0] DLY_CODE1_MS = 10'd10;
  localparam logic [9:0] DLY_CODE2_MS = 10'd100;
  localparam logic [9:0] DLY_CODE3_MS = 10'd1000;
  // Channels
  localparam int unsigned MAX_CH = 3;
  // Configuration byte layout
  localparam int unsigned CFG_FAULT_EN_BIT = 0;
  localparam int unsigned CFG_INVERT_BIT = 1;
  localparam int unsigned CFG_ON_LSB = 2;
  localparam int unsigned CFG_OFF_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_USED_MASK = 8'h3F;
  // Register byte offsets
  localparam logic [7:0] REG_CFG0 = 8'h00;
  localparam logic [7:0] REG_CFG1 = 8'h04;
  localparam logic [7:0] REG_CFG2 = 8'h08;
  localparam logic [7:0] REG_SENT = 8'h0C;
  localparam logic [7:0] REG_LIVE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Fields of one configuration byte
  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] off_dly;
    logic [1:0] on_dly;
    logic invert;
    logic fault_en;
  } cfg_s;

  // Whole module state
  typedef struct packed {
    logic [MAX_CH-1:0] line_s1;
    logic [MAX_CH-1:0] line_s2;
    logic [MAX_CH-1:0] line_s3;
    logic [MAX_CH-1:0] line_f;
    logic [MAX_CH-1:0] flt_s1;
    logic [MAX_CH-1:0] flt_s2;
    logic [MAX_CH-1:0] flt_s3;
    logic [MAX_CH-1:0] flt_f;
    logic [MAX_CH-1:0] level;
    logic [MAX_CH-1:0][9:0] dcnt;
    logic [MAX_CH-1:0][7:0] cfg;
    logic [CNT_W-1:0] tick_cnt;
    logic tick;
    logic [CNT_W-1:0] send_cnt;
    logic [7:0] data_byte;
    logic data_valid;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;
endpackage

// ==== testbench/com_unit_model.sv ====
// Purpose: Receiving end of the input byte link
// Assumes: One valid pulse per sent byte
// Notes: Keeps last byte and the gap between pulses
`timescale 1ns/1ps
`default_nettype none
module com_unit_model #(
  parameter int NUM_CH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  output logic [7:0] rx_byte,
  output int gap
);
  localparam logic [7:0] PRM_HDR = (NUM_CH == 2) ? 8'h11 : 8'h12;
  localparam logic [7:0] CFG_CODE = 8'h10;
  int cnt; // Cycles since last pulse
  // Capture byte and measure spacing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      gap <= 0;
      rx_byte <= 8'h00;
    end else if (valid_i) begin
      gap <= cnt + 1;
      cnt <= 0;
      rx_byte <= byte_i;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Register and input path checks of the conditioner
// Assumes: Short tick and send period for run time
// Notes: AXI4-Lite master tasks; no random stimulus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dic_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0] aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [2:0] line = 3'h0, flt = 3'h0;
  logic ce = 1'b1;
  logic [3:0] ws = 4'hF;
  logic awr, wrdy, bv, arr, rv, dv;
  logic [1:0] br, rr, rsp;
  logic [31:0] rd_o;
  logic [7:0] db, rx;
  int gap, err_count = 0, num_checks = 0;
  // Clock of 5 ns period
  always #2.5 clk = ~clk;
  digital_input_conditioner #(.NUM_CH(3), .TICK_LEN(4), .SEND_LEN(20)) u_dut (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .LINE_I(line), .FAULT_I(flt),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(aa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ra), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
    .S_AXI_RDATA_O(rd_o), .S_AXI_RRESP_O(rr), .DATA_BYTE_O(db), .DATA_VALID_O(dv));
  com_unit_model #(.NUM_CH(3)) u_cu (.clk(clk), .rst(rst), .byte_i(db), .valid_i(dv),
    .rx_byte(rx), .gap(gap));
  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One comparison of a 32-bit value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that ran out is a mismatch
  task automatic hang();
    err_count++;
    $display("[FAIL] handshake expected done seen stuck");
    complete_run();
  endtask
  // Write one word; channels released as taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    awv <= 1; wv <= 1; aa <= a; wd <= {24'h0, d}; bre <= 1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrdy;
      tb = bv;
      if (tb) chk("bresp", {30'h0, er}, {30'h0, br});
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) begin
        bre <= 0;
        // Let an edge pass so the next call never re-raises bready in this step
        @(posedge clk);
        return;
      end
    end
    hang();
  endtask
  // Read one word and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tv;
    arv <= 1; ra <= a; rre <= 1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = arv & arr;
      // Valid taken while settled, not in the launching edge's step
      tv = rv;
      rdat = rd_o;
      rsp = rr;
      @(posedge clk);
      if (ta) arv <= 0;
      if (tv) begin
        rre <= 0;
        chk("rdata", e, rdat);
        chk("rresp", {30'h0, er}, {30'h0, rsp});
        @(posedge clk);
        return;
      end
    end
    hang();
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(8'h00, 32'h0, RESP_OKAY);
    rc(8'h04, 32'h0, RESP_OKAY);
    rc(8'h08, 32'h0, RESP_OKAY);
    rc(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h00, 8'hFF, RESP_OKAY);
    rc(8'h00, 32'h3F, RESP_OKAY);
    // Ch2 inverted, ch3 with code 1 on and off delays, both fault off
    wr(8'h00, 8'h01, RESP_OKAY);
    wr(8'h04, 8'h02, RESP_OKAY);
    wr(8'h08, 8'h14, RESP_OKAY);
    wr(8'h10, 8'h55, RESP_OKAY);
    flt <= 3'h7;
    repeat (10) @(posedge clk);
    rc(8'h10, 32'h06, RESP_OKAY);
    repeat (45) @(posedge clk);
    chk("sent byte", 32'h06, {24'h0, rx});
    chk("send gap", 32'd20, gap);
    line <= 3'h4;
    repeat (30) @(posedge clk);
    rc(8'h10, 32'h06, RESP_OKAY);
    repeat (30) @(posedge clk);
    rc(8'h10, 32'h16, RESP_OKAY);
    line <= 3'h0;
    repeat (30) @(posedge clk);
    rc(8'h10, 32'h16, RESP_OKAY);
    repeat (30) @(posedge clk);
    rc(8'h10, 32'h06, RESP_OKAY);
    // Write with strobe 0 must leave the config byte alone
    ws <= 4'h0;
    wr(8'h00, 8'h3F, RESP_OKAY);
    ws <= 4'hF;
    rc(8'h00, 32'h01, RESP_OKAY);
    // Clock enable low drops awready and arready
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("awready frozen", 32'h0, {31'h0, awr});
    chk("arready frozen", 32'h0, {31'h0, arr});
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    rc(8'h10, 32'h06, RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
